// file: dv/mbp_ctrl_props.sv
// Checker with the concurrent properties of the monitor self-test control block.
module mbp_ctrl_props
    import mbp_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Watched ports
    input wire logic [NUM_MON-1:0] ov_in,
    input wire logic [NUM_MON-1:0] uv_in,
    input wire logic [NUM_MON-1:0] sc_in,
    input wire logic [NUM_MON-1:0] sm_mon_enable_in,
    input wire logic [NUM_MON-1:0] analog_selftest_out,
    input wire logic runtime_selftest_out,
    input wire logic [NUM_MON-1:0] mon_enable_out,
    input wire logic [NUM_MON-1:0] uv_sc_gate_out,
    input wire logic [1:0] pfsm_trigger_out,
    input wire logic safe_recovery_out,
    input wire logic [2:0] gpio_power_good_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // The longest gate is 4095 us at slew 1, so a longer run means the timer is stuck.
    logic [15:0] gate_cnt;
    logic [5:0] hist;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gate_cnt <= 16'h0000;
            hist <= 6'h00;
        end else begin
            gate_cnt <= (|uv_sc_gate_out) ? gate_cnt + 16'h0001 : 16'h0000;
            hist <= {hist[4:0], |(ov_in | uv_in | sc_in)};
        end
    end
    property p_mon_test; $rose(mon_enable_out[0]) |-> ##[0:1] analog_selftest_out[0]; endproperty
    a_mon_test: assert property (p_mon_test) else $error("enable without analog test");
    property p_sm_en; $rose(sm_mon_enable_in[2]) |-> ##[1:2] (mon_enable_out[2] && analog_selftest_out[2]); endproperty
    a_sm_en: assert property (p_sm_en) else $error("state machine enable not taken");
    property p_pin; $onehot0(gpio_power_good_out); endproperty
    a_pin: assert property (p_pin) else $error("power good on two pins");
    property p_rec; $rose(safe_recovery_out) |-> $past(runtime_selftest_out) || $past(runtime_selftest_out, 2); endproperty
    a_rec: assert property (p_rec) else $error("recovery without self-test");
    property p_dflt; $fell(safe_recovery_out) |-> ##[0:2] (mon_enable_out == MON_EN_DEFAULT); endproperty
    a_dflt: assert property (p_dflt) else $error("startup kept enables");
    property p_gate; $rose(|uv_sc_gate_out) |-> $past(runtime_selftest_out) || $past(runtime_selftest_out, 2); endproperty
    a_gate: assert property (p_gate) else $error("gate without self-test");
    property p_gate_end; gate_cnt < 16'hA0F0; endproperty
    a_gate_end: assert property (p_gate_end) else $error("gate never ends");
    property p_trig; (|pfsm_trigger_out) |-> (|hist); endproperty
    a_trig: assert property (p_trig) else $error("trigger without event");
    c_rec: cover property ($rose(safe_recovery_out));
    c_gate: cover property ($rose(|uv_sc_gate_out));
    c_trig: cover property (|pfsm_trigger_out);
endmodule // mbp_ctrl_props

bind mbp_ctrl mbp_ctrl_props i_mbp_ctrl_props (.clk_in, .rst_b_in, .ov_in, .uv_in, .sc_in, .sm_mon_enable_in,
    .analog_selftest_out, .runtime_selftest_out, .mon_enable_out, .uv_sc_gate_out, .pfsm_trigger_out,
    .safe_recovery_out, .gpio_power_good_out);

// file: dv/tb.sv
// Self-checking testbench of the monitor self-test control block.
module tb
    import mbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [ADDR_W-1:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0, runtime_selftest_done_in = 1'b0, runtime_selftest_fail_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rnd = 32'h3A6E, rdat, g;
    logic [NUM_MON-1:0] ov_in = 6'h00, uv_in = 6'h00, sc_in = 6'h00, analog_selftest_done_in = 6'h00;
    logic [NUM_MON-1:0] sm_mon_enable_in = 6'h00, analog_selftest_out, mon_enable_out, uv_sc_gate_out;
    logic avs_waitrequest_out, runtime_selftest_out, safe_recovery_out, power_good_out, irq_out;
    logic [1:0] pfsm_trigger_out, trig, pin;
    logic [2:0] gpio_power_good_out;
    int errors = 0, comparisons = 0, n, exp_n;
    mbp_ctrl i_mbp_ctrl (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .ov_in, .uv_in, .sc_in, .analog_selftest_done_in,
        .runtime_selftest_done_in, .runtime_selftest_fail_in, .analog_selftest_out, .runtime_selftest_out,
        .mon_enable_out, .uv_sc_gate_out, .sm_mon_enable_in, .pfsm_trigger_out, .safe_recovery_out,
        .power_good_out, .gpio_power_good_out, .irq_out);
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        trig = trig | pfsm_trigger_out;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    function automatic int ramp_cycles(input int lvl, input int rate);
        return ((lvl + rate - 1) / rate) * CYC_PER_US;
    endfunction
    // The master holds every signal until it samples waitrequest low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rdat = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rdat, exp);
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return runtime_selftest_out;
            1: return safe_recovery_out;
            2: return uv_sc_gate_out[0];
            default: return analog_selftest_out[0];
        endcase
    endfunction
    task automatic wait_until(input int w, input logic v);
        n = 0;
        while (sig(w) !== v && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 3000) begin
            errors++;
        end
        @(posedge clk_in);
    endtask
    initial begin
        #6_000_000;
        errors++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rchk("ramp0", OFS_RAMP0, 32'h000A0384);
        rchk("hole", 8'h80, 32'h0);
        rchk("status", OFS_STATUS, 32'h1);
        bus(1'b1, OFS_OV_MASK, 32'h1);
        bus(1'b1, OFS_UV_MASK, 32'h1);
        bus(1'b1, OFS_MON_EN, 32'h1);
        wait_until(3, 1'b1);
        check("analog0", analog_selftest_out, 32'h1);
        analog_selftest_done_in <= 6'h01;
        sm_mon_enable_in <= 6'h04;
        repeat (4) @(posedge clk_in);
        rchk("sm mask", OFS_OV_MASK, 32'h5);
        check("sm enable", mon_enable_out, 32'h5);
        analog_selftest_done_in <= 6'h05;
        repeat (5) @(posedge clk_in);
        rchk("sm unmask", OFS_OV_MASK, 32'h1);
        repeat (ramp_cycles(900, 10) + 5000) @(posedge clk_in);
        // A masked event must stay silent, the same event unmasked must reach its group.
        g = xs();
        bus(1'b1, OFS_UV_MASK, 32'h0);
        bus(1'b1, OFS_INT_MASK, 32'h1F);
        bus(1'b1, OFS_GROUP, {31'h0, g[0]});
        for (int m = 1; m >= 0; m--) begin
            bus(1'b1, OFS_OV_MASK, 32'(m));
            trig = 2'h0;
            ov_in <= 6'h01;
            repeat (8) @(posedge clk_in);
            ov_in <= 6'h00;
            check("trigger", trig, m ? 32'h0 : (g[0] ? 32'h2 : 32'h1));
            rchk("event", OFS_INT_STAT, m ? 32'h0 : 32'h4);
        end
        check("irq", irq_out, 32'h1);
        bus(1'b1, OFS_INT_STAT, 32'h1F);
        rchk("clear", OFS_INT_STAT, 32'h0);
        // Random slew and pin; the gate must last the ramp time in microseconds.
        g = xs();
        pin = 2'(g[3:2] % 3 + 1);
        exp_n = ramp_cycles(100, g[1:0] + 1);
        bus(1'b1, OFS_RAMP0, {8'h00, 8'(g[1:0]) + 8'h01, 4'h0, 12'h064});
        bus(1'b1, OFS_PG_SRC, 32'h1);
        bus(1'b1, OFS_CTRL, {26'h0, pin, 4'h0});
        repeat (4) @(negedge clk_in);
        check("pg idle", {power_good_out, gpio_power_good_out}, {1'b1, 3'h1 << (pin - 2'h1)});
        bus(1'b1, OFS_OV_MASK, 32'h3F);
        bus(1'b1, OFS_UV_MASK, 32'h3F);
        bus(1'b1, OFS_CTRL, {26'h0, pin, 4'h1});
        wait_until(0, 1'b1);
        check("pg test", power_good_out, 32'h0);
        runtime_selftest_done_in <= 1'b1;
        wait_until(2, 1'b1);
        uv_in <= 6'h01;
        bus(1'b1, OFS_UV_MASK, 32'h0);
        repeat (97) @(posedge clk_in);
        uv_in <= 6'h00;
        check("pg gate", power_good_out, 32'h0);
        wait_until(2, 1'b0);
        check("gate len", 32'((n + 100 >= exp_n) && (n + 100 <= exp_n + 4)), 32'h1);
        rchk("pass", OFS_INT_STAT, 32'h1);
        runtime_selftest_done_in <= 1'b0;
        repeat (ramp_cycles(900, 10) + 5000) @(posedge clk_in);
        bus(1'b1, OFS_PG_SRC, 32'h1);
        check("pg back", power_good_out, 32'h1);
        // Failed self-tests recover three times, then the sequencer locks.
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFS_OV_MASK, 32'h3F);
            bus(1'b1, OFS_UV_MASK, 32'h3F);
            bus(1'b1, OFS_PG_SRC, 32'h0);
            bus(1'b1, OFS_CTRL, 32'h1);
            wait_until(0, 1'b1);
            check("pg free", power_good_out, 32'h1);
            runtime_selftest_done_in <= 1'b1;
            runtime_selftest_fail_in <= 1'b1;
            wait_until(1, 1'b1);
            runtime_selftest_done_in <= 1'b0;
            runtime_selftest_fail_in <= 1'b0;
            repeat (10) @(posedge clk_in);
            rchk("status", OFS_STATUS, i < 3 ? ((i + 1) << 8) | 32'h1 : 32'h310);
            rchk("mask", OFS_OV_MASK, i < 3 ? 32'h0 : 32'h3F);
        end
        close_out();
    end
endmodule // tb

// file: hdl/mbp_ctrl.sv
// Control logic for monitor self-test, interrupt masking, comparator gating and power-good forcing.
module mbp_ctrl
    import mbp_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Analog comparators and self-test engine
    input wire logic [NUM_MON-1:0] ov_in,
    input wire logic [NUM_MON-1:0] uv_in,
    input wire logic [NUM_MON-1:0] sc_in,
    input wire logic [NUM_MON-1:0] analog_selftest_done_in,
    input wire logic runtime_selftest_done_in,
    input wire logic runtime_selftest_fail_in,
    output logic [NUM_MON-1:0] analog_selftest_out,
    output logic runtime_selftest_out,
    output logic [NUM_MON-1:0] mon_enable_out,
    output logic [NUM_MON-1:0] uv_sc_gate_out,
    // Power state machine
    input wire logic [NUM_MON-1:0] sm_mon_enable_in,
    output logic [1:0] pfsm_trigger_out,
    output logic safe_recovery_out,
    // Power-good and interrupt
    output logic power_good_out,
    output logic [2:0] gpio_power_good_out,
    output logic irq_out
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYN_W = 4 * NUM_MON + 2;
    logic [SYN_W-1:0] syn_a;
    logic [SYN_W-1:0] syn_b;
    logic [NUM_MON-1:0] ov_s;
    logic [NUM_MON-1:0] uv_s;
    logic [NUM_MON-1:0] sc_s;
    logic [NUM_MON-1:0] ast_done_s;
    logic rt_done_s;
    logic rt_fail_s;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            syn_a <= '0;
            syn_b <= '0;
        end else begin
            syn_a <= {ov_in, uv_in, sc_in, analog_selftest_done_in, runtime_selftest_done_in, runtime_selftest_fail_in};
            syn_b <= syn_a;
        end
    end

    assign {ov_s, uv_s, sc_s, ast_done_s, rt_done_s, rt_fail_s} = syn_b;

    // ****************************************
    // Bus handshake
    // ****************************************
    // Every access answers in the second cycle; waitrequest comes from a flop so the master never sees a glitch.
    logic bus_req;
    logic bus_wr;
    logic bus_rd;

    assign bus_req = avs_read_in | avs_write_in;
    assign bus_wr = avs_write_in & ~avs_waitrequest_out;
    assign bus_rd = avs_read_in & ~avs_waitrequest_out;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
        end
    end

    function automatic logic hit(input logic [ADDR_W-1:0] ofs);
        hit = bus_wr && (avs_address_in == ofs);
    endfunction

    // ****************************************
    // Registers and state
    // ****************************************
    mbp_state_t state;
    logic [NUM_MON-1:0] mon_en;
    logic [NUM_MON-1:0] ov_mask;
    logic [NUM_MON-1:0] uv_mask;
    logic [NUM_MON-1:0] pg_src;
    logic [NUM_MON-1:0] group_sel;
    logic [1:0] pg_pin;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [RCNT_W-1:0] rec_cnt;
    logic [NUM_MON-1:0] sm_en_d;
    logic [NUM_MON-1:0] sm_pending;
    logic [VOUT_W-1:0] vout [NUM_MON];
    logic [SLEW_W-1:0] slew [NUM_MON];
    logic [NUM_MON-1:0] supp_busy;
    logic [NUM_MON-1:0] sm_rise;
    logic [NUM_MON-1:0] sw_rise;
    logic [NUM_MON-1:0] next_mon_en;
    logic start_req;
    logic rt_pass;
    logic rt_fail;
    logic reload;

    assign start_req = hit(OFS_CTRL) && avs_writedata_in[CTRL_START_BIT] && (state == MBP_IDLE);
    assign rt_pass = (state == MBP_SELFTEST) && rt_done_s && !rt_fail_s;
    assign rt_fail = (state == MBP_SELFTEST) && rt_done_s && rt_fail_s;
    assign reload = (state == MBP_STARTUP);
    assign sm_rise = sm_mon_enable_in & ~sm_en_d;
    assign next_mon_en = hit(OFS_MON_EN) ? avs_writedata_in[NUM_MON-1:0] : mon_en;
    assign sw_rise = next_mon_en & ~mon_en;

    // ****************************************
    // Self-test sequencer
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= MBP_IDLE;
            rec_cnt <= '0;
        end else begin
            case (state)
                MBP_IDLE: begin
                    if (start_req) begin
                        state <= MBP_SELFTEST;
                    end
                end
                MBP_SELFTEST: begin
                    if (rt_fail) begin
                        state <= MBP_RECOVER;
                    end else if (rt_pass) begin
                        state <= MBP_IDLE;
                    end
                end
                MBP_RECOVER: begin
                    if (rec_cnt < RECOVERY_LIMIT) begin
                        rec_cnt <= rec_cnt + 4'h1;
                        state <= MBP_STARTUP;
                    end else begin
                        state <= MBP_LOCKED;
                    end
                end
                MBP_STARTUP: begin
                    state <= MBP_IDLE;
                end
                MBP_LOCKED: begin
                    state <= MBP_LOCKED;
                end
                default: begin
                    state <= MBP_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Monitor configuration
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mon_en <= MON_EN_DEFAULT;
            ov_mask <= '0;
            uv_mask <= '0;
            pg_src <= PG_SRC_DEFAULT;
            group_sel <= GROUP_DEFAULT;
            pg_pin <= PGPIN_DEFAULT;
            sm_en_d <= '0;
            sm_pending <= '0;
        end else if (reload) begin
            mon_en <= MON_EN_DEFAULT;
            ov_mask <= '0;
            uv_mask <= '0;
            pg_src <= PG_SRC_DEFAULT;
            group_sel <= GROUP_DEFAULT;
            pg_pin <= PGPIN_DEFAULT;
            sm_en_d <= sm_mon_enable_in;
            sm_pending <= '0;
        end else begin
            sm_en_d <= sm_mon_enable_in;
            // A state-machine enable masks first; the unmask waits for the analog self-test to finish.
            ov_mask <= (hit(OFS_OV_MASK) ? avs_writedata_in[NUM_MON-1:0] : ov_mask & ~(sm_pending & ast_done_s))
                | sm_rise;
            uv_mask <= (hit(OFS_UV_MASK) ? avs_writedata_in[NUM_MON-1:0] : uv_mask & ~(sm_pending & ast_done_s))
                | sm_rise;
            sm_pending <= (sm_pending & ~ast_done_s) | sm_rise;
            mon_en <= next_mon_en | sm_rise;
            if (hit(OFS_PG_SRC)) begin
                pg_src <= avs_writedata_in[NUM_MON-1:0];
            end
            if (hit(OFS_GROUP)) begin
                group_sel <= avs_writedata_in[NUM_MON-1:0];
            end
            if (hit(OFS_CTRL)) begin
                pg_pin <= avs_writedata_in[CTRL_PGPIN_LSB +: 2];
            end
        end
    end

    // ****************************************
    // Ramp settings and gating timers
    // ****************************************
    for (genvar i = 0; i < NUM_MON; i++) begin : g_mon
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                vout[i] <= VOUT_DEFAULT;
                slew[i] <= SLEW_DEFAULT;
            end else if (reload) begin
                vout[i] <= VOUT_DEFAULT;
                slew[i] <= SLEW_DEFAULT;
            end else if (hit(OFS_RAMP0 + 8'(4 * i))) begin
                vout[i] <= avs_writedata_in[VOUT_W-1:0];
                slew[i] <= avs_writedata_in[RAMP_SLEW_LSB +: SLEW_W];
            end
        end

        mbp_ramp_timer u_ramp (
            .clk_in(clk_in),
            .rst_b_in(rst_b_in),
            .start_in(rt_pass),
            .vout_in(vout[i]),
            .slew_in(slew[i]),
            .busy_out(supp_busy[i])
        );
    end

    // ****************************************
    // Analog self-test requests
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            analog_selftest_out <= '0;
            mon_enable_out <= '0;
        end else if (reload) begin
            analog_selftest_out <= '0;
            mon_enable_out <= MON_EN_DEFAULT;
        end else begin
            analog_selftest_out <= (analog_selftest_out & ~ast_done_s) | sw_rise | sm_rise;
            mon_enable_out <= next_mon_en | sm_rise;
        end
    end

    // ****************************************
    // Runtime self-test and comparator gating
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            runtime_selftest_out <= 1'b0;
            safe_recovery_out <= 1'b0;
            uv_sc_gate_out <= '0;
        end else begin
            runtime_selftest_out <= (state == MBP_SELFTEST) ? !rt_done_s : start_req;
            safe_recovery_out <= rt_fail || (state == MBP_RECOVER) || (state == MBP_LOCKED);
            uv_sc_gate_out <= rt_pass ? mon_en : (uv_sc_gate_out & supp_busy);
        end
    end

    // ****************************************
    // Monitor events and triggers
    // ****************************************
    logic [NUM_MON-1:0] ov_evt;
    logic [NUM_MON-1:0] uv_evt;
    logic [NUM_MON-1:0] sc_evt;
    logic [NUM_MON-1:0] any_evt;
    logic [INT_W-1:0] evt;

    assign ov_evt = ov_s & mon_en & ~ov_mask;
    assign uv_evt = uv_s & mon_en & ~uv_mask & ~uv_sc_gate_out;
    assign sc_evt = sc_s & mon_en & ~uv_sc_gate_out;
    assign any_evt = ov_evt | uv_evt;
    assign evt = {|sc_evt, |uv_evt, |ov_evt, rt_fail, rt_pass};

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pfsm_trigger_out <= 2'h0;
        end else begin
            pfsm_trigger_out <= {|(any_evt & group_sel), |(any_evt & ~group_sel)};
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    // A new event in the cycle of its write-one-to-clear keeps the bit set.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            int_stat <= '0;
            int_mask <= '0;
            irq_out <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~(hit(OFS_INT_STAT) ? avs_writedata_in[INT_W-1:0] : '0)) | evt;
            if (hit(OFS_INT_MASK)) begin
                int_mask <= avs_writedata_in[INT_W-1:0];
            end
            irq_out <= |(int_stat & int_mask);
        end
    end

    // ****************************************
    // Power-good generation and pin routing
    // ****************************************
    logic pg_force;
    logic pg_level;

    assign pg_force = ((state == MBP_SELFTEST) || (|supp_busy) || rt_pass) && (|pg_src);
    assign pg_level = !pg_force && !(|(pg_src & (ov_s | uv_s)));

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            power_good_out <= 1'b0;
            gpio_power_good_out <= 3'h0;
        end else begin
            power_good_out <= pg_level;
            gpio_power_good_out <= {pg_pin == PGPIN_GPIO9, pg_pin == PGPIN_GPIO6, pg_pin == PGPIN_GPIO1}
                & {3{pg_level}};
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        case (avs_address_in)
            OFS_CTRL: rdata[CTRL_PGPIN_LSB +: 2] = pg_pin;
            OFS_MON_EN: rdata[NUM_MON-1:0] = mon_en;
            OFS_OV_MASK: rdata[NUM_MON-1:0] = ov_mask;
            OFS_UV_MASK: rdata[NUM_MON-1:0] = uv_mask;
            OFS_PG_SRC: rdata[NUM_MON-1:0] = pg_src;
            OFS_GROUP: rdata[NUM_MON-1:0] = group_sel;
            OFS_INT_STAT: rdata[INT_W-1:0] = int_stat;
            OFS_INT_MASK: rdata[INT_W-1:0] = int_mask;
            OFS_STATUS: rdata = {10'h000, supp_busy, 4'h0, rec_cnt, 3'h0, state};
            default: begin
                for (int k = 0; k < NUM_MON; k++) begin
                    if (avs_address_in == OFS_RAMP0 + 8'(4 * k)) begin
                        rdata = {8'h00, slew[k], 4'h0, vout[k]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (bus_req && avs_waitrequest_out) begin
            avs_readdata_out <= rdata;
        end
    end

endmodule // mbp_ctrl

// file: hdl/mbp_pkg.sv
// Package with register map, field positions, reset values and timing counts of the monitor self-test control block.
package mbp_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_MON = 6;
    localparam int NUM_REG = 4;
    localparam int VOUT_W = 12;
    localparam int SLEW_W = 8;
    localparam int ADDR_W = 8;
    localparam int RCNT_W = 4;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int US_PER_TICK = 1;
    localparam logic [3:0] CYC_PER_US = 4'(CLK_HZ / 1_000_000 * US_PER_TICK);
    localparam logic [RCNT_W-1:0] RECOVERY_LIMIT = 4'h3;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MON_EN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OV_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_UV_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PG_SRC = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_GROUP = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_RAMP0 = 8'h24;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_PGPIN_LSB = 4;
    localparam int RAMP_SLEW_LSB = 16;
    localparam int INT_PASS = 0;
    localparam int INT_FAIL = 1;
    localparam int INT_OV = 2;
    localparam int INT_UV = 3;
    localparam int INT_SC = 4;
    localparam int INT_W = 5;
    localparam int STAT_RCNT_LSB = 8;
    localparam int STAT_SUPP_LSB = 16;

    // ****************************************
    // Reset and default values
    // ****************************************
    localparam logic [NUM_MON-1:0] MON_EN_DEFAULT = 6'h00;
    localparam logic [NUM_MON-1:0] PG_SRC_DEFAULT = 6'h00;
    localparam logic [NUM_MON-1:0] GROUP_DEFAULT = 6'h00;
    localparam logic [1:0] PGPIN_DEFAULT = 2'h0;
    localparam logic [VOUT_W-1:0] VOUT_DEFAULT = 12'h384;
    localparam logic [SLEW_W-1:0] SLEW_DEFAULT = 8'h0A;

    // ****************************************
    // Power-good pin choice
    // ****************************************
    localparam logic [1:0] PGPIN_NONE = 2'h0;
    localparam logic [1:0] PGPIN_GPIO1 = 2'h1;
    localparam logic [1:0] PGPIN_GPIO6 = 2'h2;
    localparam logic [1:0] PGPIN_GPIO9 = 2'h3;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [4:0] {
        MBP_IDLE = 5'h01,
        MBP_SELFTEST = 5'h02,
        MBP_RECOVER = 5'h04,
        MBP_STARTUP = 5'h08,
        MBP_LOCKED = 5'h10
    } mbp_state_t;

endpackage

// file: hdl/mbp_ramp_timer.sv
// Ramp timer that stays busy for programmed output level over programmed slew rate.
module mbp_ramp_timer
    import mbp_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Control
    input wire logic start_in,
    input wire logic [VOUT_W-1:0] vout_in,
    input wire logic [SLEW_W-1:0] slew_in,
    // Status
    output logic busy_out
);

    // ****************************************
    // Microsecond accumulation
    // ****************************************
    // Adding the slew each microsecond avoids a divider; a zero slew counts as one so the timer always ends.
    logic [3:0] us_cnt;
    logic [VOUT_W:0] acc;
    logic [VOUT_W:0] next_acc;
    logic [SLEW_W-1:0] slew_eff;

    always_comb begin
        slew_eff = (slew_in == '0) ? 8'h01 : slew_in;
        next_acc = acc + {5'h00, slew_eff};
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            us_cnt <= 4'h0;
            acc <= '0;
            busy_out <= 1'b0;
        end else if (start_in) begin
            us_cnt <= 4'h0;
            acc <= '0;
            busy_out <= 1'b1;
        end else if (busy_out) begin
            if (us_cnt == CYC_PER_US - 4'h1) begin
                us_cnt <= 4'h0;
                acc <= next_acc;
                if (next_acc >= {1'b0, vout_in}) begin
                    busy_out <= 1'b0;
                end
            end else begin
                us_cnt <= us_cnt + 4'h1;
            end
        end
    end

endmodule // mbp_ramp_timer
